// ### hdl/bcd_pkg.sv
package bcd_pkg;
    localparam int unsigned BCD_SYNC_STAGES = 2;
    localparam logic [1:0]  BCD_SYNC_RESET  = 2'h3;
    localparam logic [4:0]  BCD_HIGH_ADDR_TAG = 5'h1e;

    typedef enum logic [1:0] {
        BCD_IDLE    = 2'h0,
        BCD_ACTIVE  = 2'h1,
        BCD_CLK_LOW = 2'h2
    } bcd_bus_t;

    typedef enum logic [1:0] {
        BCD_GEN_NONE  = 2'h0,
        BCD_GEN_START = 2'h1,
        BCD_GEN_STOP  = 2'h2
    } bcd_gen_t;
endpackage

// ### hdl/bcd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser; only stage two is visible
module bcd_sync
    import bcd_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;
    logic sync_r;

    // Idle lines are high, so reset to high to avoid a phantom edge
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            meta_r <= BCD_SYNC_RESET[0];
            sync_r <= BCD_SYNC_RESET[1];
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule
`default_nettype wire

// ### hdl/bcd_i2c_bus_condition_detect.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_i2c_bus_condition_detect
    import bcd_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_gen_start,
    input  wire logic       i_gen_stop,
    input  wire logic       i_slave_mode,
    input  wire logic       i_mode_irq_on_cond,
    input  wire logic       i_start_detect_irq_enable,
    input  wire logic       i_stop_detect_irq_enable,
    input  wire logic       i_addr_ten_bit,
    input  wire logic       i_addr_byte_valid,
    input  wire logic [7:0] i_addr_byte,
    input  wire logic       i_high_match,
    input  wire logic       i_low_match,
    input  wire logic       i_stretch_release,
    output logic            o_sda_oe,
    output logic            o_scl_oe,
    output logic            o_start_det,
    output logic            o_stop_det,
    output logic            o_restart_det,
    output logic            o_bus_active,
    output logic            o_bus_collision,
    output logic            o_slave_reset,
    output logic            o_prior_match,
    output logic            o_tx_prepare,
    output logic            o_cond_irq
);
    logic     scl_s;
    logic     sda_s;
    logic     scl_d_r;
    logic     sda_d_r;
    logic     start_ev;
    logic     stop_ev;
    bcd_bus_t bus_r;
    bcd_gen_t gen_r;
    logic     sda_oe_r;
    logic     stretch_r;
    logic     bcol_r;
    logic     start_r;
    logic     stop_r;
    logic     restart_r;
    logic     prior_r;
    logic     high_read;

    // Line levels cross into i_mclk before any edge logic reads them
    bcd_sync u_scl_sync (.i_mclk(i_mclk), .i_srst(i_srst), .i_async(i_scl), .o_sync(scl_s));
    bcd_sync u_sda_sync (.i_mclk(i_mclk), .i_srst(i_srst), .i_async(i_sda), .o_sync(sda_s));

    // Delayed synchronised copies for edge finding
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Conditions: data edge while clock stays high in both samples
    assign start_ev = sda_d_r && !sda_s && scl_d_r && scl_s;
    assign stop_ev  = !sda_d_r && sda_s && scl_d_r && scl_s;

    // Bus state; Stop only armed after a clock-low interval
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            bus_r <= BCD_IDLE;
        end else if (start_ev) begin
            bus_r <= BCD_ACTIVE;
        end else begin
            unique case (bus_r)
                BCD_IDLE: begin
                    bus_r <= BCD_IDLE;
                end
                BCD_ACTIVE: begin
                    if (!scl_s) begin
                        bus_r <= BCD_CLK_LOW;
                    end
                end
                BCD_CLK_LOW: begin
                    if (stop_ev) begin
                        bus_r <= BCD_IDLE;
                    end
                end
                default: begin
                    bus_r <= BCD_IDLE;
                end
            endcase
        end
    end

    // Detect pulses; a Restart is a Start seen where a Stop would count
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            start_r   <= 1'b0;
            stop_r    <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            start_r   <= start_ev;
            stop_r    <= stop_ev && (bus_r == BCD_CLK_LOW);
            restart_r <= start_ev && (bus_r == BCD_CLK_LOW);
        end
    end

    // Master generation: drive data low for Start, release for Stop
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            gen_r    <= BCD_GEN_NONE;
            sda_oe_r <= 1'b0;
            bcol_r   <= 1'b0;
        end else begin
            bcol_r <= 1'b0;
            unique case (gen_r)
                BCD_GEN_NONE: begin
                    if (i_gen_start) begin
                        gen_r <= BCD_GEN_START;
                    end else if (i_gen_stop) begin
                        gen_r <= BCD_GEN_STOP;
                        sda_oe_r <= 1'b1;
                    end
                end
                BCD_GEN_START: begin
                    // Line already low before we pull it: someone else owns it
                    if (!sda_s) begin
                        bcol_r <= 1'b1;
                    end else if (scl_s) begin
                        sda_oe_r <= 1'b1;
                    end
                    gen_r <= BCD_GEN_NONE;
                end
                BCD_GEN_STOP: begin
                    if (scl_s) begin
                        sda_oe_r <= 1'b0;
                        gen_r    <= BCD_GEN_NONE;
                    end
                end
                default: begin
                    gen_r <= BCD_GEN_NONE;
                end
            endcase
        end
    end

    // High address byte with read bit set, 10-bit mode only
    assign high_read = i_addr_ten_bit && i_addr_byte_valid && i_addr_byte[0]
                       && (i_addr_byte[7:3] == BCD_HIGH_ADDR_TAG);

    // Prior-match flag; a set beats any clear in the same cycle, but only sets while the flag is clear, so a repeat match with a clear drops it
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            prior_r <= 1'b0;
        end else if (i_addr_ten_bit && i_addr_byte_valid && i_low_match && prior_r == 1'b0
                     && !i_addr_byte[0] && i_high_match) begin
            prior_r <= 1'b1;
        end else if (stop_r) begin
            prior_r <= 1'b0;
        end else if (i_addr_ten_bit && i_addr_byte_valid && (i_addr_byte[7:3] == BCD_HIGH_ADDR_TAG)
                     && (!i_high_match || !i_addr_byte[0])) begin
            prior_r <= 1'b0;
        end
    end

    // Clock stretch after a matched read request; held until firmware loads data or a Start is detected
    always_ff @(posedge i_mclk) begin
        if (i_srst || start_r) begin
            stretch_r <= 1'b0;
        end else if (high_read && prior_r && i_high_match && i_slave_mode) begin
            stretch_r <= 1'b1;
        end else if (i_stretch_release) begin
            stretch_r <= 1'b0;
        end
    end

    // Interrupt: the enables only add to slave modes lacking condition interrupts
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_cond_irq <= 1'b0;
        end else if (i_mode_irq_on_cond) begin
            o_cond_irq <= start_r || stop_r;
        end else begin
            o_cond_irq <= i_slave_mode && ((start_r && i_start_detect_irq_enable)
                                           || (stop_r && i_stop_detect_irq_enable));
        end
    end

    assign o_sda_oe        = sda_oe_r;
    assign o_scl_oe        = stretch_r;
    assign o_start_det     = start_r;
    assign o_stop_det      = stop_r;
    assign o_restart_det   = restart_r;
    assign o_bus_active    = (bus_r != BCD_IDLE);
    assign o_bus_collision = bcol_r;
    assign o_slave_reset   = start_r;
    assign o_prior_match   = prior_r;
    assign o_tx_prepare    = stretch_r;
endmodule
`default_nettype wire

// ### testbench/bcd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_monitor (
    input wire logic       i_mclk, i_srst, i_scl, i_sda, i_gen_start, i_slave_mode,
    input wire logic       i_mode_irq_on_cond, i_start_detect_irq_enable, i_addr_ten_bit,
    input wire logic       i_addr_byte_valid, i_high_match, i_low_match, i_stretch_release,
    input wire logic [7:0] i_addr_byte,
    input wire logic       o_scl_oe, o_start_det, o_stop_det, o_restart_det, o_bus_active,
    input wire logic       o_bus_collision, o_slave_reset, o_prior_match, o_cond_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Sync flops plus compare place the pulse a few clocks after the pin edge
    a_start_seen: assert property ($fell(i_sda) && i_scl |-> ##[3:5] o_start_det) else $error("start late");
    a_start_bus: assert property (o_start_det |-> ##[0:1] o_bus_active) else $error("bus idle");
    a_stop_idle: assert property (o_stop_det |-> ##[0:1] !o_bus_active) else $error("bus busy");
    a_restart_clears: assert property (o_restart_det |-> o_start_det && o_slave_reset) else $error("restart");
    a_irq_cause: assert property (o_cond_irq |-> $past(o_start_det || o_stop_det)) else $error("stray irq");
    a_irq_start: assert property (
        o_start_det && (i_mode_irq_on_cond || i_slave_mode && i_start_detect_irq_enable)
        |=> o_cond_irq) else $error("no irq");
    // Request is taken one clock, line compared the next, flag shows a clock later
    a_collision_cause: assert property (o_bus_collision |-> $past(i_gen_start, 2)) else $error("collision");
    a_prior_set: assert property (
        i_addr_byte_valid && i_addr_ten_bit && i_high_match && i_low_match
        && !i_addr_byte[0] |=> o_prior_match) else $error("prior unset");
    a_prior_clear: assert property (o_stop_det |=> !o_prior_match) else $error("prior kept");
    a_stretch_hold: assert property (
        o_scl_oe && !i_stretch_release && !o_start_det |=> o_scl_oe) else $error("stretch lost");
    c_restart: cover property (o_restart_det);
    c_collision: cover property (o_bus_collision);
    c_stretch: cover property ($fell(o_scl_oe));
endmodule
bind bcd_i2c_bus_condition_detect bcd_monitor chk_u (.*);
`default_nettype wire

// ### testbench/bcd_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_partner (
    input wire logic i_mclk,
    output logic     o_scl = 1'b1,
    output logic     o_sda = 1'b1
);
    // Half of the 320 ns link period in system clocks
    localparam int HALF = 4;
    task automatic hold(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // Data only moves while the clock is low, so no false conditions appear
    task automatic put(input logic b);
        o_scl <= 1'b0;
        hold(HALF);
        o_sda <= b;
        hold(HALF);
        o_scl <= 1'b1;
        hold(HALF);
    endtask
    task automatic start;
        o_sda <= 1'b0;
        hold(2 * HALF);
    endtask
    task automatic lift;
        o_sda <= 1'b1;
        hold(2 * HALF);
    endtask
    task automatic stop;
        put(1'b0);
        lift;
    endtask
    task automatic restart;
        put(1'b1);
        start;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bcd_pkg::*;
    logic       i_mclk = 1'b0, i_srst = 1'b1, i_gen_start = 1'b0, i_gen_stop = 1'b0, i_slave_mode = 1'b0;
    logic       i_mode_irq_on_cond = 1'b0, i_start_detect_irq_enable = 1'b0, i_stop_detect_irq_enable = 1'b0;
    logic       i_addr_ten_bit = 1'b0, i_addr_byte_valid = 1'b0, i_high_match = 1'b0, i_low_match = 1'b0;
    logic       i_stretch_release = 1'b0;
    logic [7:0] i_addr_byte = 8'h00;
    logic       o_sda_oe, o_scl_oe, o_start_det, o_stop_det, o_restart_det, o_bus_active, o_bus_collision;
    logic       o_slave_reset, o_prior_match, o_tx_prepare, o_cond_irq, p_scl, p_sda;
    wire        i_scl = p_scl & ~o_scl_oe;
    wire        i_sda = p_sda & ~o_sda_oe;
    logic [7:0] n_st = 8'h00, n_sp = 8'h00, n_rs = 8'h00, n_irq = 8'h00, n_col = 8'h00;
    int         fails = 0, samples_checked = 0;
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end
    bcd_i2c_bus_condition_detect DUT (.*);
    bcd_partner pm (.i_mclk(i_mclk), .o_scl(p_scl), .o_sda(p_sda));
    // Pulses last one cycle, so totals are kept and compared later
    always @(posedge i_mclk) begin
        n_st  <= n_st + {7'h00, o_start_det === 1'b1};
        n_sp  <= n_sp + {7'h00, o_stop_det === 1'b1};
        n_rs  <= n_rs + {7'h00, o_restart_det === 1'b1};
        n_irq <= n_irq + {7'h00, o_cond_irq === 1'b1};
        n_col <= n_col + {7'h00, o_bus_collision === 1'b1};
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic byte_in(input logic [7:0] b);
        i_addr_byte <= b;
        i_addr_byte_valid <= 1'b1;
        cyc(1);
        i_addr_byte_valid <= 1'b0;
        cyc(3);
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // The sequence needs well under a thousand clocks; this only cuts a hang
    initial begin
        #100us;
        fails++;
        stop_test;
    end
    // Data glitch with the clock high must count only as a start
    initial begin
        cyc(4);
        i_srst <= 1'b0;
        i_slave_mode <= 1'b1;
        i_start_detect_irq_enable <= 1'b1;
        cyc(2);
        chk(o_bus_active, 8'h00);
        pm.start;
        pm.lift;
        chk(n_st, 8'h01);
        chk(n_sp, 8'h00);
        chk(o_bus_active, 8'h01);
        chk(n_irq, 8'h01);
        pm.put(1'b1);
        pm.stop;
        chk(n_sp, 8'h01);
        chk(o_bus_active, 8'h00);
        chk(n_irq, 8'h01);
        i_start_detect_irq_enable <= 1'b0;
        i_stop_detect_irq_enable <= 1'b1;
        i_addr_ten_bit <= 1'b1;
        i_high_match <= 1'b1;
        i_low_match <= 1'b1;
        pm.start;
        pm.put(1'b0);
        pm.restart;
        chk(n_rs, 8'h01);
        chk(n_st, 8'h03);
        chk(n_irq, 8'h01);
        byte_in(8'hf0);
        byte_in(8'h5a);
        chk(o_prior_match, 8'h01);
        pm.restart;
        byte_in(8'hf1);
        chk(o_tx_prepare, 8'h01);
        i_stretch_release <= 1'b1;
        cyc(1);
        i_stretch_release <= 1'b0;
        cyc(2);
        chk(o_scl_oe, 8'h00);
        pm.stop;
        chk(o_prior_match, 8'h00);
        chk(n_irq, 8'h02);
        i_stop_detect_irq_enable <= 1'b0;
        i_mode_irq_on_cond <= 1'b1;
        pm.start;
        chk(n_irq, 8'h03);
        i_gen_start <= 1'b1;
        cyc(1);
        i_gen_start <= 1'b0;
        cyc(3);
        chk(n_col, 8'h01);
        pm.stop;
        stop_test;
    end
endmodule
`default_nettype wire
